// *** rtl/video_decoder_format_window_regs_defines.vh ***
`ifndef VIDEO_DECODER_FORMAT_WINDOW_REGS_DEFINES_VH
`define VIDEO_DECODER_FORMAT_WINDOW_REGS_DEFINES_VH

// Register indexes inside one input's set; byte address is four times index
`define DECODER_STATUS 6'h00
`define STANDARD_SELECT 6'h01
`define GAIN_OFFSET_CONTROL 6'h02
`define HSTART_LOW_PATH_X 6'h03
`define HSIZE_LOW_PATH_X 6'h04
`define HSTART_LOW_PATH_Y 6'h05
`define HSIZE_LOW_PATH_Y 6'h06
`define HORIZONTAL_HIGH_BITS 6'h07
`define HSYNC_WIDTH 6'h08
`define VSTART_LOW_PATH_X 6'h09
`define VSIZE_LOW_PATH_X 6'h0a
`define VSTART_LOW_PATH_Y 6'h0b
`define VSIZE_LOW_PATH_Y 6'h0c
`define VERTICAL_HIGH_BITS 6'h0d
`define LAST_REG_INDEX 6'h0d
// Spacing of the per-input copies, in register indexes
`define CHANNEL_STRIDE 8'h40

// Reset values
`define STANDARD_SELECT_RESET 8'h00
`define GAIN_OFFSET_CONTROL_RESET 8'h05
`define HSTART_LOW_RESET 8'h20
`define HSIZE_LOW_RESET 8'hd0
`define HORIZONTAL_HIGH_RESET 8'h88
`define HSYNC_WIDTH_RESET 8'h20
`define VSTART_LOW_RESET 8'h06
`define VSIZE_LOW_RESET 8'hf0
`define VERTICAL_HIGH_RESET 8'h40

// Writable bit masks and bits that read as a constant one
`define STANDARD_SELECT_WMASK 8'hf0
`define STANDARD_SELECT_FIXED 8'h04
`define GAIN_OFFSET_CONTROL_WMASK 8'hcf
`define GAIN_OFFSET_CONTROL_FIXED 8'h20
`define HSYNC_WIDTH_WMASK 8'h3f

// Field positions
`define MANUAL_STANDARD_BIT 7
`define FORCED_STANDARD_MSB 6
`define FORCED_STANDARD_LSB 4
`define NONSTANDARD_SOURCE_BIT 1
`define FIELD_RATE_SIXTY_BIT 0
`define GAIN_ENABLE_BIT 7
`define SETUP_LEVEL_SEL_BIT 6
`define GAIN_LOOP_SPEED_MSB 3
`define GAIN_LOOP_SPEED_LSB 2
`define OFFSET_LOOP_SPEED_MSB 1
`define OFFSET_LOOP_SPEED_LSB 0
`define HSTART_X_HIGH_LSB 0
`define HSIZE_X_HIGH_LSB 2
`define HSTART_Y_HIGH_LSB 4
`define HSIZE_Y_HIGH_LSB 6
`define VSIZE_X_HIGH_BIT 0
`define VSTART_X_HIGH_BIT 1
`define VSIZE_Y_HIGH_BIT 2
`define VSTART_Y_HIGH_BIT 3

// AHB-Lite encodings
`define HTRANS_NONSEQ 2'b10
`define HRESP_OKAY 1'b0

`endif

// *** rtl/video_decoder_format_window_regs.v ***
// What this block does
// - Each input reports its detected standard as a read-only 3-bit code.
// - Read-only flag shows whether colour is present on the input.
// - Read-only flag shows colour demodulation loop lock.
// - Read-only flag shows gain control loop lock.
// - Read-only flag shows clamping loop lock.
// - Read-only flag shows horizontal PLL lock.
// - Manual bit clear: automatic standard detection; set: forced standard.
// - Forced standard applies in manual mode and when no video is seen.
// - Read-only flag shows a non-standard source.
// - Read-only flag shows field rate, zero for 50 Hz, one for 60 Hz.
// - Gain enable bit turns on gain control; resets to off.
// - Pedestal bit picks 0 IRE or 7.5 IRE as the black code.
// - Two-bit gain loop speed field, default slow.
// - Two-bit offset loop speed field, default slow.
// - Ten-bit horizontal start per path, default 32 pixels.
// - Ten-bit horizontal size per path, default 720 pixels.
// - Six-bit horizontal sync width in pixels, default 32.
// - Nine-bit vertical start per path, default line 6.
// - Nine-bit vertical size per path, default 240 lines.
//
// Decided for this implementation: register access over AHB-Lite.
`include "video_decoder_format_window_regs_defines.vh"

module video_decoder_format_window_regs (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   // Decoder status, four inputs packed low input first
   input wire [11:0] detected_standard,
   input wire [3:0] colour_present,
   input wire [3:0] colour_loop_locked,
   input wire [3:0] gain_loop_locked,
   input wire [3:0] clamp_loop_locked,
   input wire [3:0] hpll_locked,
   input wire [3:0] nonstandard_source,
   input wire [3:0] field_rate_sixty,
   input wire [3:0] video_present,
   // Decoder control
   output reg [11:0] active_standard,
   output reg [3:0] gain_enable,
   output reg [3:0] setup_level_sel,
   output reg [7:0] gain_loop_speed,
   output reg [7:0] offset_loop_speed,
   output reg [23:0] hsync_pulse_width,
   // Active window per input and output path
   output reg [39:0] horizontal_start_x,
   output reg [39:0] horizontal_start_y,
   output reg [39:0] horizontal_size_x,
   output reg [39:0] horizontal_size_y,
   output reg [35:0] vertical_start_x,
   output reg [35:0] vertical_start_y,
   output reg [35:0] vertical_size_x,
   output reg [35:0] vertical_size_y
);

   // Storage: index {input, register[3:0]}
   reg [7:0] bank [0:63];

   reg wr_pending;
   reg [5:0] wr_index;
   reg [7:0] next_rdata;
   reg [1:0] rd_ch;
   reg [5:0] rd_reg;

   wire access = hsel & hready & (htrans == `HTRANS_NONSEQ);
   wire [7:0] idx = haddr[9:2];
   wire mapped = (haddr[31:10] == 22'h000000) &&
      (idx[5:0] <= `LAST_REG_INDEX);

   function [7:0] reset_value;
      input [3:0] r;
      begin
         case ({2'b00, r})
            `STANDARD_SELECT: reset_value = `STANDARD_SELECT_RESET;
            `GAIN_OFFSET_CONTROL: reset_value = `GAIN_OFFSET_CONTROL_RESET;
            `HSTART_LOW_PATH_X: reset_value = `HSTART_LOW_RESET;
            `HSTART_LOW_PATH_Y: reset_value = `HSTART_LOW_RESET;
            `HSIZE_LOW_PATH_X: reset_value = `HSIZE_LOW_RESET;
            `HSIZE_LOW_PATH_Y: reset_value = `HSIZE_LOW_RESET;
            `HORIZONTAL_HIGH_BITS: reset_value = `HORIZONTAL_HIGH_RESET;
            `HSYNC_WIDTH: reset_value = `HSYNC_WIDTH_RESET;
            `VSTART_LOW_PATH_X: reset_value = `VSTART_LOW_RESET;
            `VSTART_LOW_PATH_Y: reset_value = `VSTART_LOW_RESET;
            `VSIZE_LOW_PATH_X: reset_value = `VSIZE_LOW_RESET;
            `VSIZE_LOW_PATH_Y: reset_value = `VSIZE_LOW_RESET;
            `VERTICAL_HIGH_BITS: reset_value = `VERTICAL_HIGH_RESET;
            default: reset_value = 8'h00;
         endcase
      end
   endfunction

   function [7:0] write_mask;
      input [3:0] r;
      begin
         case ({2'b00, r})
            `DECODER_STATUS: write_mask = 8'h00;
            `STANDARD_SELECT: write_mask = `STANDARD_SELECT_WMASK;
            `GAIN_OFFSET_CONTROL: write_mask = `GAIN_OFFSET_CONTROL_WMASK;
            `HSYNC_WIDTH: write_mask = `HSYNC_WIDTH_WMASK;
            6'h0e: write_mask = 8'h00;
            6'h0f: write_mask = 8'h00;
            default: write_mask = 8'hff;
         endcase
      end
   endfunction

   // Bus address phase: capture writes, load read data for the data phase
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wr_pending <= 1'b0;
         wr_index <= 6'h00;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= `HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp <= `HRESP_OKAY;
         wr_pending <= access & hwrite & mapped;
         if (access) begin
            wr_index <= {idx[7:6], idx[3:0]};
         end
         if (access & ~hwrite) begin
            hrdata <= {24'h000000, next_rdata};
         end
      end
   end

   // Read value; status bits are live, read-only bits ignore writes
   always @* begin
      rd_ch = idx[7:6];
      rd_reg = idx[5:0];
      next_rdata = 8'h00;
      if (mapped) begin
         next_rdata = bank[{rd_ch, rd_reg[3:0]}] & write_mask(rd_reg[3:0]);
         case (rd_reg)
            `DECODER_STATUS: begin
               next_rdata = {detected_standard[rd_ch*3 +: 3],
                  colour_present[rd_ch],
                  colour_loop_locked[rd_ch],
                  gain_loop_locked[rd_ch],
                  clamp_loop_locked[rd_ch],
                  hpll_locked[rd_ch]};
            end
            `STANDARD_SELECT: begin
               next_rdata = next_rdata | `STANDARD_SELECT_FIXED;
               next_rdata[`NONSTANDARD_SOURCE_BIT] =
                  nonstandard_source[rd_ch];
               next_rdata[`FIELD_RATE_SIXTY_BIT] =
                  field_rate_sixty[rd_ch];
            end
            `GAIN_OFFSET_CONTROL: begin
               next_rdata = next_rdata | `GAIN_OFFSET_CONTROL_FIXED;
            end
            default: begin
               next_rdata = next_rdata;
            end
         endcase
      end
   end

   // One storage byte per input and register; only writable bits change
   genvar e;
   generate
      for (e = 0; e < 64; e = e + 1) begin : entry
         localparam [5:0] EI = e;
         always @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               bank[e] <= reset_value(EI[3:0]);
            end else if (wr_pending && wr_index == EI) begin
               bank[e] <= (bank[e] & ~write_mask(EI[3:0])) |
                  (hwdata[7:0] & write_mask(EI[3:0]));
            end
         end
      end
   endgenerate

   // Control outputs per input, registered from the storage
   genvar c;
   generate
      for (c = 0; c < 4; c = c + 1) begin : chan
         wire [7:0] sel = bank[c*16 + 1];
         wire [7:0] gctl = bank[c*16 + 2];
         wire [7:0] hhi = bank[c*16 + 7];
         wire [7:0] vhi = bank[c*16 + 13];
         always @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               active_standard[c*3 +: 3] <= 3'h0;
               gain_enable[c] <= 1'b0;
               setup_level_sel[c] <= 1'b0;
               gain_loop_speed[c*2 +: 2] <= 2'h1;
               offset_loop_speed[c*2 +: 2] <= 2'h1;
               hsync_pulse_width[c*6 +: 6] <= 6'h20;
               horizontal_start_x[c*10 +: 10] <= 10'h020;
               horizontal_start_y[c*10 +: 10] <= 10'h020;
               horizontal_size_x[c*10 +: 10] <= 10'h2d0;
               horizontal_size_y[c*10 +: 10] <= 10'h2d0;
               vertical_start_x[c*9 +: 9] <= 9'h006;
               vertical_start_y[c*9 +: 9] <= 9'h006;
               vertical_size_x[c*9 +: 9] <= 9'h0f0;
               vertical_size_y[c*9 +: 9] <= 9'h0f0;
            end else begin
               // Free-run in the forced standard while no video is seen
               if (sel[`MANUAL_STANDARD_BIT] || !video_present[c]) begin
                  active_standard[c*3 +: 3] <=
                     sel[`FORCED_STANDARD_MSB:`FORCED_STANDARD_LSB];
               end else begin
                  active_standard[c*3 +: 3] <=
                     detected_standard[c*3 +: 3];
               end
               gain_enable[c] <= gctl[`GAIN_ENABLE_BIT];
               setup_level_sel[c] <= gctl[`SETUP_LEVEL_SEL_BIT];
               gain_loop_speed[c*2 +: 2] <=
                  gctl[`GAIN_LOOP_SPEED_MSB:`GAIN_LOOP_SPEED_LSB];
               offset_loop_speed[c*2 +: 2] <=
                  gctl[`OFFSET_LOOP_SPEED_MSB:`OFFSET_LOOP_SPEED_LSB];
               hsync_pulse_width[c*6 +: 6] <= bank[c*16 + 8][5:0];
               horizontal_start_x[c*10 +: 10] <=
                  {hhi[`HSTART_X_HIGH_LSB +: 2], bank[c*16 + 3]};
               horizontal_start_y[c*10 +: 10] <=
                  {hhi[`HSTART_Y_HIGH_LSB +: 2], bank[c*16 + 5]};
               horizontal_size_x[c*10 +: 10] <=
                  {hhi[`HSIZE_X_HIGH_LSB +: 2], bank[c*16 + 4]};
               horizontal_size_y[c*10 +: 10] <=
                  {hhi[`HSIZE_Y_HIGH_LSB +: 2], bank[c*16 + 6]};
               vertical_start_x[c*9 +: 9] <=
                  {vhi[`VSTART_X_HIGH_BIT], bank[c*16 + 9]};
               vertical_start_y[c*9 +: 9] <=
                  {vhi[`VSTART_Y_HIGH_BIT], bank[c*16 + 11]};
               vertical_size_x[c*9 +: 9] <=
                  {vhi[`VSIZE_X_HIGH_BIT], bank[c*16 + 10]};
               vertical_size_y[c*9 +: 9] <=
                  {vhi[`VSIZE_Y_HIGH_BIT], bank[c*16 + 12]};
            end
         end
      end
   endgenerate

endmodule

// *** dv/video_decoder_format_window_regs_asserts.sv ***
module fmt_win_checker (
   // Bus
   input logic sys_clk, reset, hsel, hwrite, hready, hreadyout, hresp,
   input logic [1:0] htrans,
   input logic [31:0] haddr, hwdata, hrdata,
   // Status and control
   input logic [11:0] detected_standard,
   input logic [3:0] colour_present, colour_loop_locked, gain_loop_locked,
   input logic [3:0] clamp_loop_locked, hpll_locked, nonstandard_source,
   input logic [3:0] field_rate_sixty, gain_enable, setup_level_sel,
   input logic [7:0] gain_loop_speed, offset_loop_speed,
   input logic [39:0] horizontal_size_x
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire go = hsel && hready && htrans == 2'b10;
   wire rd = go && !hwrite;
   wire wr = go && hwrite;
   a_bus_ready: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_upper_zero: assert property (rd |=> hrdata[31:8] == 24'h0)
      else $error("read upper bits not zero");
   a_status_live: assert property (
      rd && haddr == 32'h0 |=> hrdata[7:0] == $past({detected_standard[2:0],
      colour_present[0], colour_loop_locked[0], gain_loop_locked[0],
      clamp_loop_locked[0], hpll_locked[0]}))
      else $error("status byte wrong");
   a_flags_live: assert property (
      rd && haddr == 32'h4 |=> hrdata[3:0] == {2'b01,
      $past(nonstandard_source[0]), $past(field_rate_sixty[0])})
      else $error("standard flags wrong");
   a_unmapped_zero: assert property (
      rd && (haddr[7:2] > 6'h0d || haddr[31:10] != 0) |=> hrdata == 0)
      else $error("unmapped read not zero");
   a_reset_dflt: assert property (
      $fell(reset) |-> gain_enable == 0 && setup_level_sel == 0 &&
      gain_loop_speed == 8'h55 && offset_loop_speed == 8'h55 &&
      horizontal_size_x == {4{10'd720}})
      else $error("control defaults wrong");
   a_gain_map: assert property (
      wr && haddr == 32'h8 |=> ##2 {gain_enable[0], setup_level_sel[0],
      gain_loop_speed[1:0], offset_loop_speed[1:0]} ==
      $past({hwdata[7:6], hwdata[3:0]}, 2))
      else $error("gain controls not applied");
   a_ctrl_on_write: assert property (
      !$stable({gain_enable, setup_level_sel, gain_loop_speed,
      offset_loop_speed, horizontal_size_x}) |-> $past(wr, 2) || $past(wr, 3))
      else $error("control changed without write");
endmodule

bind video_decoder_format_window_regs fmt_win_checker u_chk (
   .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .htrans(htrans),
   .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata),
   .detected_standard(detected_standard), .colour_present(colour_present),
   .colour_loop_locked(colour_loop_locked),
   .gain_loop_locked(gain_loop_locked), .hpll_locked(hpll_locked),
   .clamp_loop_locked(clamp_loop_locked), .gain_enable(gain_enable),
   .nonstandard_source(nonstandard_source), .setup_level_sel(setup_level_sel),
   .field_rate_sixty(field_rate_sixty), .gain_loop_speed(gain_loop_speed),
   .offset_loop_speed(offset_loop_speed),
   .horizontal_size_x(horizontal_size_x));

// *** dv/video_source_model.sv ***
module video_source_model (
   // Commanded status for one input
   input logic [1:0] vin,
   input logic [2:0] std_code,
   input logic [6:0] flag_set,
   // Status lines of all four inputs
   output logic [11:0] detected_standard,
   output logic [3:0] colour_present, colour_loop_locked, gain_loop_locked,
   output logic [3:0] clamp_loop_locked, hpll_locked, nonstandard_source,
   output logic [3:0] field_rate_sixty
);
   timeunit 1ns;
   timeprecision 1ps;
   // Other inputs show the inverse so a wrong input index is caught
   always_comb begin
      for (int n = 0; n < 4; n++) begin
         detected_standard[3*n+:3] = (n == vin) ? std_code : ~std_code;
         {colour_present[n], colour_loop_locked[n], gain_loop_locked[n],
            clamp_loop_locked[n], hpll_locked[n], nonstandard_source[n],
            field_rate_sixty[n]} = (n == vin) ? flag_set : ~flag_set;
      end
   end
endmodule

// *** dv/testbench.sv ***
`include "video_decoder_format_window_regs_defines.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, reset = 1, hsel = 0, hwrite = 0;
   logic [1:0] htrans = 0, vin = 0;
   logic [2:0] std_code = 0;
   logic [6:0] flag_set = 0, f;
   logic [3:0] video_present = 4'hf;
   logic [31:0] haddr = 0, hwdata = 0, rdata;
   wire hreadyout, hresp;
   wire [31:0] hrdata;
   wire [11:0] det, act;
   wire [3:0] c_p, c_l, g_l, k_l, p_l, n_s, f_r, g_e, s_l;
   wire [7:0] g_s, o_s;
   wire [23:0] hsw;
   wire [39:0] hsx, hsy, hzx, hzy;
   wire [35:0] vsx, vsy, vzx, vzy;
   int num_errors = 0, n_checks = 0;
   logic [7:0] rst_tab [14] = '{8'h00, 8'h04, 8'h25, 8'h20, 8'hd0, 8'h20,
      8'hd0, 8'h88, 8'h20, 8'h06, 8'hf0, 8'h06, 8'hf0, 8'h40};
   logic [7:0] wtab [3:13] = '{8'h34, 8'h11, 8'h56, 8'h78, 8'h1b, 8'hff,
      8'h9a, 8'hbc, 8'hde, 8'hf1, 8'h3a};

   video_decoder_format_window_regs u_dut (
      .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .detected_standard(det), .colour_present(c_p),
      .colour_loop_locked(c_l), .gain_loop_locked(g_l),
      .clamp_loop_locked(k_l), .hpll_locked(p_l), .nonstandard_source(n_s),
      .field_rate_sixty(f_r), .video_present(video_present),
      .active_standard(act), .gain_enable(g_e), .setup_level_sel(s_l),
      .gain_loop_speed(g_s), .offset_loop_speed(o_s),
      .hsync_pulse_width(hsw), .horizontal_start_x(hsx),
      .horizontal_start_y(hsy), .horizontal_size_x(hzx),
      .horizontal_size_y(hzy), .vertical_start_x(vsx),
      .vertical_start_y(vsy), .vertical_size_x(vzx), .vertical_size_y(vzy));
   video_source_model u_src (.vin(vin), .std_code(std_code),
      .flag_set(flag_set), .detected_standard(det), .colour_present(c_p),
      .colour_loop_locked(c_l), .gain_loop_locked(g_l),
      .clamp_loop_locked(k_l), .hpll_locked(p_l),
      .nonstandard_source(n_s), .field_rate_sixty(f_r));

   initial forever #4 sys_clk = ~sys_clk;

   task wrap_up;
      if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 40);
      if (k >= 40) begin
         num_errors++;
         wrap_up;
      end
   endtask
   task xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
      @(posedge sys_clk);
      hsel <= 1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy;
      hsel <= 0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      wait_rdy;
      rdata = hrdata;
   endtask
   task settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   function automatic logic [31:0] ra(input int ch, input int r);
      return 32'((ch * 64 + r) * 4);
   endfunction

   initial begin
      repeat (4) @(posedge sys_clk);
      reset <= 0;
      for (int r = 0; r < 14; r++) begin
         xfer(ra(0, r), 0, 0);
         chk(rdata, {24'h0, rst_tab[r]});
      end
      for (int s = 0; s < 7; s++) begin
         f = 7'h2a ^ {s[2:0], s[2:0], s[0]};
         vin <= 2'd2;
         std_code <= 3'(s);
         flag_set <= f;
         xfer(ra(2, `DECODER_STATUS), 1, 8'hff);
         xfer(ra(2, `DECODER_STATUS), 0, 0);
         chk(rdata, {24'h0, 3'(s), f[6:2]});
         xfer(ra(2, `STANDARD_SELECT), 0, 0);
         chk(rdata, {24'h0, 6'h01, f[1:0]});
      end
      vin <= 2'd1;
      std_code <= 3'd4;
      flag_set <= 7'h03;
      xfer(ra(1, `STANDARD_SELECT), 1, 8'hd0);
      xfer(ra(1, `STANDARD_SELECT), 0, 0);
      chk(rdata, 32'hd7);
      settle;
      chk({20'h0, act}, {20'h0, 12'h6eb});
      xfer(ra(1, `STANDARD_SELECT), 1, 8'h50);
      settle;
      chk({20'h0, act}, {20'h0, 12'h6e3});
      xfer(ra(1, `STANDARD_SELECT), 0, 0);
      video_present <= 4'hd;
      settle;
      chk({20'h0, act}, {20'h0, 12'h6eb});
      xfer(ra(0, `GAIN_OFFSET_CONTROL), 1, 8'hff);
      xfer(ra(0, `GAIN_OFFSET_CONTROL), 0, 0);
      chk(rdata, 32'hef);
      chk({g_e, s_l, g_s, o_s}, 24'h115757);
      xfer(ra(0, `GAIN_OFFSET_CONTROL), 1, 8'h44);
      xfer(ra(0, `GAIN_OFFSET_CONTROL), 0, 0);
      chk(rdata, 32'h64);
      chk({g_e, s_l, g_s, o_s}, 24'h015554);
      for (int r = 3; r < 14; r++) xfer(ra(3, r), 1, wtab[r]);
      for (int r = 3; r < 14; r++) begin
         xfer(ra(3, r), 0, 0);
         chk(rdata, {24'h0, wtab[r] & (r == 8 ? 8'h3f : 8'hff)});
      end
      chk({2'b0, hsx[39:30], hzx[39:30], hsy[39:30]},
         {2'b0, 10'h334, 10'h211, 10'h156});
      chk({16'h0, hzy[39:30], hsw[23:18]}, 32'h1e3f);
      chk({vsx[35:27], vzx[35:27], vsy[35:27], 5'h0},
         {9'h19a, 9'h0bc, 9'h1de, 5'h0});
      chk({23'h0, vzy[35:27]}, 32'hf1);
      chk({22'h0, hsx[9:0]}, 32'd32);
      xfer(ra(0, 14), 1, 8'hff);
      xfer(ra(0, 14), 0, 0);
      chk(rdata, 32'h0);
      xfer(32'h400, 0, 0);
      chk(rdata, 32'h0);
      xfer(ra(0, `STANDARD_SELECT), 1, 8'hc4);
      xfer(ra(0, `STANDARD_SELECT), 0, 0);
      chk(rdata, 32'hc4);
      @(posedge sys_clk);
      reset <= 1;
      repeat (2) @(posedge sys_clk);
      reset <= 0;
      xfer(ra(0, `GAIN_OFFSET_CONTROL), 0, 0);
      chk(rdata, 32'h25);
      wrap_up;
   end
endmodule
